//--- design/dps_cnt.sv
`timescale 1ns/1ps
module dps_cnt import dps_pkg::*; (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic load, // Load length
  input wire logic [7:0] len, // Cycles to count
  output logic done // High when count is zero
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  assign nxt_cnt = load ? len : (cnt_ff != CNT_ZERO ? cnt_ff - 8'h01 : cnt_ff);
  // Load is left out so done never loops through the caller's next state
  assign done = (cnt_ff == CNT_ZERO);
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= CNT_ZERO;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // dps_cnt

//--- design/dps_host.sv
`timescale 1ns/1ps
module dps_host import dps_pkg::*; (
  input wire logic clk, // Clock
  input wire logic srst, // Sync reset
  input wire logic ce, // Clock enable
  input wire logic req_valid, // Request strobe
  input wire dps_req_t req, // Request contents
  output logic req_ready, // Idle, request taken
  output logic rsp_valid, // One-cycle done pulse
  output logic [DATA_W-1:0] rsp_rdata, // Read data
  output logic rsp_granted, // Semaphore won
  output dps_pins_t pins, // Control and address pins
  output logic [DATA_W-1:0] dq_o, // Data out
  output logic dq_oe, // Data drive enable
  input wire logic [DATA_W-1:0] dq_i, // Data pins in
  input wire logic busy_n_i, // Busy pin in
  input wire logic int_n_i, // Doorbell pin in
  input wire logic role_master, // Arbiter role pin in
  output logic busy_n_o, // Busy drive, held high and never enabled
  output logic busy_n_oe, // Busy enable
  output logic doorbell // Synced doorbell level
);
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_SETUP = 6'b000010,
    S_PULSE = 6'b000100,
    S_HOLD = 6'b001000,
    S_READ = 6'b010000,
    S_GAP = 6'b100000
  } dps_st_t;
  dps_st_t st_ff, nxt_st;
  dps_req_t req_ff;
  dps_pins_t pins_ff, nxt_pins;
  logic [DATA_W-1:0] dq_ff, rdata_ff;
  logic dq_oe_ff, rsp_ff, grant_ff, ready_ff;
  logic sem_rd_ff, bell_ff;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic [2:0] in_s1_ff, in_s2_ff;
  logic load;
  logic [7:0] len;
  logic done;
  logic is_sem, is_write, sem_chain, busy_n_s;
  logic take, role_master_s, write_go, drive_go;
  logic hold_end, read_end, gap_end;
  logic [DATA_W-1:0] wdata_sel;
  dps_cnt u_cnt (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .load(load),
    .len(len),
    .done(done)
  );
  function automatic dps_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    dps_pins_t p;
    p = '{port_sel_n: 1'b1, token_flag_select_n: 1'b1, rw_n: 1'b1,
      oe_n: 1'b1, upper_lane_select_n: 1'b1, lower_lane_select_n: 1'b1,
      addr: a};
    return p;
  endfunction
  assign is_sem = req_ff.op[1];
  assign is_write = req_ff.op != OP_READ;
  assign take = (st_ff == S_IDLE) && req_valid && ready_ff;
  // Semaphore write is always read back to learn the outcome
  assign sem_chain = is_sem && sem_rd_ff;
  assign busy_n_s = in_s2_ff[0];
  assign role_master_s = in_s2_ff[2];
  // Busy stall only matters when device is a slave reading busy
  assign write_go = done && (busy_n_s || role_master_s);
  // Drive starts a cycle after the strobe falls, stops as it rises
  assign drive_go = (st_ff == S_PULSE) && (nxt_st == S_PULSE);
  assign hold_end = (st_ff == S_HOLD) && done;
  assign read_end = (st_ff == S_READ) && done;
  assign gap_end = (st_ff == S_GAP) && done;
  assign wdata_sel = (req_ff.op == OP_SEM_REQ) ?
    {DATA_W{1'b1}} ^ 16'h0001 :
    (req_ff.op == OP_SEM_REL) ? {DATA_W{1'b1}} : req_ff.wdata;
  assign load = ce && (st_ff != nxt_st);
  always_comb begin
    nxt_st = st_ff;
    nxt_pins = pins_ff;
    len = 8'h00;
    case (st_ff)
      S_IDLE: begin
        if (take) begin
          nxt_st = S_SETUP;
          len = 8'(C_SETUP);
        end
      end
      S_SETUP: begin
        if (done) begin
          nxt_pins.rw_n = !is_write;
          if (is_sem) begin
            nxt_pins.token_flag_select_n = 1'b0;
            nxt_pins.oe_n = is_write;
          end else begin
            nxt_pins.port_sel_n = 1'b0;
            nxt_pins.upper_lane_select_n = !req_ff.lanes[1];
            nxt_pins.lower_lane_select_n = !req_ff.lanes[0];
            nxt_pins.oe_n = is_write ? !req_ff.oe_during_write : 1'b0;
          end
          nxt_st = is_write ? S_PULSE : S_READ;
          len = 8'((is_write && !nxt_pins.oe_n) ? C_PULSE_OE :
            (is_write ? C_PULSE : C_READ));
        end
      end
      S_PULSE: begin
        if (write_go) begin
          nxt_pins.rw_n = 1'b1;
          nxt_pins.port_sel_n = 1'b1;
          nxt_pins.token_flag_select_n = 1'b1;
          nxt_st = S_HOLD;
          len = 8'(C_HOLD);
        end
      end
      S_READ: begin
        if (done) begin
          nxt_pins = idle_pins(pins_ff.addr);
          nxt_st = S_GAP;
          len = 8'(C_GAP);
        end
      end
      S_HOLD: begin
        if (done) begin
          nxt_pins = idle_pins(pins_ff.addr);
          nxt_st = S_GAP;
          len = 8'(C_GAP);
        end
      end
      S_GAP: begin
        if (done && sem_chain) begin
          // Read back the flag with the array still deselected
          nxt_pins.token_flag_select_n = 1'b0;
          nxt_pins.oe_n = 1'b0;
          nxt_st = S_READ;
          len = 8'(C_READ);
        end else if (done) begin
          nxt_st = S_IDLE;
        end
      end
      default: begin
        nxt_st = S_IDLE;
        nxt_pins = idle_pins(pins_ff.addr);
      end
    endcase
  end
  // Two flops on every pin input before any logic reads it
  always_ff @(posedge clk) begin
    if (srst) begin
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
      in_s1_ff <= 3'h7;
      in_s2_ff <= 3'h7;
    end else if (ce) begin
      dq_s1_ff <= dq_i;
      dq_s2_ff <= dq_s1_ff;
      in_s1_ff <= {role_master, int_n_i, busy_n_i};
      in_s2_ff <= in_s1_ff;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      st_ff <= S_IDLE;
      pins_ff <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, '0};
      ready_ff <= 1'b0;
      sem_rd_ff <= 1'b0;
    end else if (ce) begin
      st_ff <= nxt_st;
      pins_ff <= nxt_pins;
      ready_ff <= (nxt_st == S_IDLE);
      if (take) begin
        pins_ff.addr <= req.addr;
      end
      // Marks the gap between flag write and read-back
      if (hold_end) begin
        sem_rd_ff <= is_sem;
      end else if (gap_end) begin
        sem_rd_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      req_ff <= '0;
      dq_ff <= '0;
      dq_oe_ff <= 1'b0;
    end else if (ce) begin
      if (take) begin
        req_ff <= req;
      end
      if (st_ff == S_SETUP) begin
        dq_ff <= wdata_sel;
      end
      // Selects fall with the strobe, so the outputs stay off
      dq_oe_ff <= drive_go;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= '0;
      rsp_ff <= 1'b0;
      grant_ff <= 1'b0;
      bell_ff <= 1'b0;
    end else if (ce) begin
      rsp_ff <= read_end || (hold_end && !is_sem);
      if (read_end) begin
        rdata_ff <= dq_s2_ff;
        grant_ff <= is_sem && !dq_s2_ff[0];
      end
      bell_ff <= !in_s2_ff[1];
    end
  end
  assign req_ready = ready_ff;
  assign rsp_valid = rsp_ff;
  assign rsp_rdata = rdata_ff;
  assign rsp_granted = grant_ff;
  assign pins = pins_ff;
  assign dq_o = dq_ff;
  assign dq_oe = dq_oe_ff;
  // Host never drives busy; device arbitrates it
  assign busy_n_o = 1'b1;
  assign busy_n_oe = 1'b0;
  assign doorbell = bell_ff;
endmodule // dps_host

//--- design/dps_pkg.sv
// How it works
// - Read-write select high during address changes
// - Hold address after write end
// - Stretch write pulse when outputs enabled
// - No data drive while device drives
// - Port select high through semaphore operations
// - Semaphore request writes low on bit zero
// - Address valid by port select fall
// - Read-write select high through reads
// - Writing one releases a held flag
package dps_pkg;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  // Ns figures for the fastest grade
  localparam int CLK_PS = 5000;
  localparam int T_WRITE_PULSE_NS = 12;
  localparam int T_TURNOFF_NS = 10;
  localparam int T_DATA_SETUP_NS = 10;
  localparam int T_ADDR_SETUP_NS = 0;
  localparam int T_READ_CYCLE_NS = 15;
  localparam int T_FLAG_W2R_NS = 5;
  localparam int T_FLAG_PULSE_NS = 10;
  localparam int T_ADDR_HOLD_NS = 0;
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int C_PULSE = cyc_min(T_WRITE_PULSE_NS);
  localparam int C_PULSE_OE =
    cyc_min(T_TURNOFF_NS + T_DATA_SETUP_NS) > C_PULSE ?
    cyc_min(T_TURNOFF_NS + T_DATA_SETUP_NS) : C_PULSE;
  localparam int C_SETUP = cyc_min(T_ADDR_SETUP_NS);
  localparam int C_READ = cyc_min(T_READ_CYCLE_NS);
  localparam int C_GAP = cyc_min(T_FLAG_W2R_NS) > cyc_min(T_FLAG_PULSE_NS) ?
    cyc_min(T_FLAG_W2R_NS) : cyc_min(T_FLAG_PULSE_NS);
  localparam int C_HOLD = cyc_min(T_ADDR_HOLD_NS);
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SEM_REQ = 2'h2;
  localparam logic [1:0] OP_SEM_REL = 2'h3;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  typedef struct packed {
    logic [1:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] lanes;
    logic oe_during_write;
  } dps_req_t;
  typedef struct packed {
    logic port_sel_n;
    logic token_flag_select_n;
    logic rw_n;
    logic oe_n;
    logic upper_lane_select_n;
    logic lower_lane_select_n;
    logic [ADDR_W-1:0] addr;
  } dps_pins_t;
endpackage

//--- tb/dps_checker.sv
`timescale 1ns/1ps
module dps_checker import dps_pkg::*; (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic req_ready, // Idle
  input wire dps_pins_t pins, // Pins
  input wire logic dq_oe, // Drive
  input wire logic busy_n_oe // Busy drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_ADDR_RW: assert property ($changed(pins.addr) |-> pins.rw_n)
    else $error("address moved in write");
  AST_HOLD: assert property ($rose(pins.rw_n) |-> $stable(pins.addr))
    else $error("address not held");
  AST_PULSE: assert property ($fell(pins.rw_n) |-> !pins.rw_n [*3])
    else $error("write pulse short");
  AST_PULSE_OE: assert property
    ($fell(pins.rw_n) && !pins.oe_n |-> !pins.rw_n [*4])
    else $error("pulse short with oe");
  AST_NO_CLASH: assert property ($rose(dq_oe) |-> $past(!pins.rw_n))
    else $error("drove data too early");
  AST_DRIVE_WR: assert property (dq_oe |-> !pins.rw_n)
    else $error("data driven outside write");
  AST_SEM_SEL: assert property
    (!pins.token_flag_select_n |-> pins.port_sel_n)
    else $error("array selected in flag op");
  AST_ADDR_SEL: assert property
    (!pins.port_sel_n && $past(!pins.port_sel_n) |-> $stable(pins.addr))
    else $error("address moved while selected");
  AST_IDLE: assert property (req_ready |->
    pins.port_sel_n && pins.token_flag_select_n && !dq_oe)
    else $error("selects active while idle");
  AST_BUSY_DIR: assert property (!busy_n_oe)
    else $error("busy driven");
  cover property ($rose(dq_oe));
  cover property ($fell(pins.token_flag_select_n));
  cover property ($fell(pins.oe_n) && pins.rw_n);
endmodule // dps_checker

//--- tb/dps_sram_model.sv
`timescale 1ns/1ps
module dps_sram_model import dps_pkg::*; (
  input wire logic clk, // Clock
  input wire dps_pins_t pins, // Host pins
  input wire logic [DATA_W-1:0] dq_o, // Host data
  input wire logic dq_oe, // Host drive
  input wire logic other_holds, // Far port owns flag
  output logic [DATA_W-1:0] dq_i // Data to host
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic held_ff = 1'b0;
  logic [DATA_W-1:0] last_ff = 16'h0000;
  wire mem_sel = !pins.port_sel_n && pins.token_flag_select_n;
  wire sem_sel = pins.port_sel_n && !pins.token_flag_select_n;
  wire [1:0] lane = sem_sel ? 2'h3 :
    ~{pins.upper_lane_select_n, pins.lower_lane_select_n};
  // Outputs off in any write cycle
  wire rd = pins.rw_n && !pins.oe_n && (mem_sel || sem_sel);
  wire [DATA_W-1:0] val = sem_sel ? {15'h7FFF, !held_ff} :
    mem[pins.addr];
  // Released lanes show inverted data, not a stale copy
  assign dq_i = {rd && lane[1] ? val[15:8] : ~last_ff[15:8],
    rd && lane[0] ? val[7:0] : ~last_ff[7:0]};
  always @(posedge clk) begin
    last_ff <= dq_i;
    if (!pins.rw_n && dq_oe && mem_sel) begin
      if (lane[1]) mem[pins.addr][15:8] <= dq_o[15:8];
      if (lane[0]) mem[pins.addr][7:0] <= dq_o[7:0];
    end
    if (!pins.rw_n && dq_oe && sem_sel) begin
      if (dq_o[0]) held_ff <= 1'b0;
      else if (!other_holds) held_ff <= 1'b1;
    end
  end
endmodule // dps_sram_model

//--- tb/test_dps_host.sv
`timescale 1ns/1ps
module test_dps_host import dps_pkg::*; ();
  logic clk = 1'b0, srst = 1'b1, req_valid = 1'b0, busy_n_i = 1'b1;
  logic int_n_i = 1'b1, role_master = 1'b1, other_holds = 1'b0;
  dps_req_t req = '0;
  logic req_ready, rsp_valid, rsp_granted, dq_oe, busy_n_o, busy_n_oe;
  logic doorbell;
  logic [DATA_W-1:0] rsp_rdata, dq_o, dq_i;
  dps_pins_t pins;
  int failures = 0, num_checks = 0;
  always #2.5 clk = ~clk;
  dps_host DUT (.clk, .srst, .ce(1'b1), .req_valid, .req, .req_ready,
    .rsp_valid, .rsp_rdata, .rsp_granted, .pins, .dq_o, .dq_oe, .dq_i,
    .busy_n_i, .int_n_i, .role_master, .busy_n_o, .busy_n_oe, .doorbell);
  dps_sram_model m (.clk, .pins, .dq_o, .dq_oe, .other_holds, .dq_i);
  task automatic chk(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic run(input logic [1:0] op, input logic [12:0] a,
      input logic [15:0] d, input logic [1:0] ln, input logic oe);
    @(negedge clk);
    req = '{op, a, d, ln, oe};
    req_valid = 1'b1;
    do @(posedge clk); while (req_ready !== 1'b1);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (300) begin
      if (rsp_valid === 1'b1) break;
      @(negedge clk);
    end
    chk(rsp_valid, 1'b1);
  endtask
  task automatic t_mem();
    run(OP_WRITE, 13'h1ABC, 16'hA55A, 2'h3, 1'b0);
    run(OP_WRITE, 13'h1FFF, 16'h0FF0, 2'h3, 1'b1);
    run(OP_WRITE, 13'h1ABC, 16'h3CC3, 2'h2, 1'b1);
    run(OP_READ, 13'h1ABC, 16'h0000, 2'h3, 1'b0);
    chk(rsp_rdata, 16'h3C5A);
    run(OP_READ, 13'h1FFF, 16'h0000, 2'h1, 1'b0);
    chk(rsp_rdata[7:0], 8'hF0);
  endtask
  task automatic t_sem();
    other_holds = 1'b1;
    run(OP_SEM_REQ, 13'h0003, 16'hFFFE, 2'h0, 1'b0);
    chk(m.held_ff, 1'b0);
    chk(rsp_granted, 1'b0);
    other_holds = 1'b0;
    run(OP_SEM_REQ, 13'h0003, 16'hFFFE, 2'h0, 1'b0);
    chk(m.held_ff, 1'b1);
    chk(rsp_granted, 1'b1);
    chk(rsp_rdata[0], 1'b0);
    run(OP_SEM_REL, 13'h0003, 16'h0001, 2'h0, 1'b0);
    chk(m.held_ff, 1'b0);
    chk(rsp_granted, 1'b0);
  endtask
  task automatic t_busy();
    role_master = 1'b0;
    busy_n_i = 1'b0;
    fork
      run(OP_WRITE, 13'h0040, 16'h1234, 2'h3, 1'b0);
    join_none
    repeat (40) @(negedge clk);
    chk(req_ready, 1'b0);
    chk(pins.rw_n, 1'b0);
    busy_n_i = 1'b1;
    wait fork;
    chk(busy_n_oe, 1'b0);
    chk(busy_n_o, 1'b1);
    run(OP_READ, 13'h0040, 16'h0000, 2'h3, 1'b0);
    chk(rsp_rdata, 16'h1234);
    role_master = 1'b1;
  endtask
  task automatic t_bell();
    int_n_i = 1'b0;
    repeat (4) @(negedge clk);
    chk(doorbell, 1'b1);
    int_n_i = 1'b1;
    repeat (4) @(negedge clk);
    chk(doorbell, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    t_mem();
    t_sem();
    t_busy();
    t_bell();
    report_and_stop();
  end
  // Whole run is a few hundred cycles
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
endmodule // test_dps_host
bind dps_host dps_checker chk_i (.clk(clk), .srst(srst),
  .req_ready(req_ready), .pins(pins), .dq_oe(dq_oe), .busy_n_oe(busy_n_oe));
